// ===== core/tbs_seq_map.vh
`ifndef TBS_SEQ_MAP_VH
`define TBS_SEQ_MAP_VH

// clock 250 MHz
`define TBS_CLK_MHZ 250
// switching period ~550 kHz -> 455 cycles; phase step 120 deg = period/3
`define TBS_SW_PERIOD 16'h01C7
`define TBS_PHASE_STEP 16'h0097
`define TBS_PHASE_STEP2 16'h012E
// min on-time as 5 percent duty (cycles)
`define TBS_MIN_ON 16'h0017
// soft-start 1.25 ms
`define TBS_SS_US 1250
`define TBS_SS_CYCLES (`TBS_SS_US * `TBS_CLK_MHZ)
// por interval: 2.131e5 s/F x 470 nF ~ 100 ms default
`define TBS_POR_US 100157
`define TBS_POR_CYCLES (`TBS_POR_US * `TBS_CLK_MHZ)

// register map
`define TBS_REG_CTRL 12'h000
`define TBS_REG_STATUS 12'h004
`define TBS_REG_POR 12'h008
`define TBS_CTRL_RESET 32'h0000_0000
`define TBS_RESP_OKAY 2'b00
`define TBS_RESP_DECERR 2'b11

`endif

// ===== core/tbs_seq.v
// ---------------------------------------------------------------
// Summary of operation
// ---------------------------------------------------------------
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`include "tbs_seq_map.vh"

module tbs_seq #(
  parameter SS_CYCLES = `TBS_SS_CYCLES,
  parameter POR_CYCLES = `TBS_POR_CYCLES
)
(
  input wire aclk,
  input wire aresetn,
  input wire [2:0] channel_enable_x,
  input wire [2:0] fb_above_85,
  input wire [2:0] fb_below_80,
  input wire [2:0] current_at_demand,
  input wire [2:0] current_at_limit,
  input wire [2:0] duty_below_min,
  input wire thermal_shutdown,
  input wire external_logic_supply,
  input wire above_startup_level,
  input wire above_combined_startup_level,
  input wire above_internal_shutdown_level,
  input wire above_external_shutdown_level,
  input wire above_warning_level,
  output reg pump_enable,
  output reg [2:0] switch_on,
  output reg [2:0] soft_start_active,
  output reg [2:0] channel_run,
  output reg [15:0] ref_ramp_1,
  output reg [15:0] ref_ramp_2,
  output reg [15:0] ref_ramp_3,
  output reg power_good_n_out,
  output reg power_good_n_oe_n,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam NIN = 24;
  wire [NIN-1:0] raw_in;
  reg [NIN-1:0] sync_a;
  reg [NIN-1:0] sync_b;
  assign raw_in = {channel_enable_x, fb_above_85, fb_below_80, current_at_demand,
    current_at_limit, duty_below_min, thermal_shutdown, external_logic_supply,
    above_startup_level, above_combined_startup_level, above_internal_shutdown_level,
    above_external_shutdown_level};
  wire [2:0] s_en = sync_b[23:21];
  wire [2:0] s_fb85 = sync_b[20:18];
  wire [2:0] s_fb80 = sync_b[17:15];
  wire [2:0] s_dem = sync_b[14:12];
  wire [2:0] s_lim = sync_b[11:9];
  wire [2:0] s_skip = sync_b[8:6];
  wire s_tsd = sync_b[5];
  wire s_ext = sync_b[4];
  wire s_su = sync_b[3];
  wire s_cpsu = sync_b[2];
  wire s_sd_int = sync_b[1];
  wire s_sd_ext = sync_b[0];
  reg warn_a;
  reg warn_b;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_a <= {NIN{1'b0}};
      sync_b <= {NIN{1'b0}};
      warn_a <= 1'b0;
      warn_b <= 1'b0;
    end
    else
    begin
      sync_a <= raw_in;
      sync_b <= sync_a;
      warn_a <= above_warning_level;
      warn_b <= warn_a;
    end
  end

  // ---------------------------------------------------------------
  // registers: ctrl bit0 = software override hold-off, por count
  // ---------------------------------------------------------------
  reg [31:0] ctrl;
  reg [31:0] por_count;
  reg por_expired;

  // ---------------------------------------------------------------
  // undervoltage lockout
  // ---------------------------------------------------------------
  reg ext_seen;
  reg supply_ok;
  reg pump_ok;
  wire sd_ok = ext_seen ? s_sd_ext : s_sd_int;
  wire all_ok = supply_ok & pump_ok & ~s_tsd & ~ctrl[0];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_seen <= 1'b0;
      supply_ok <= 1'b0;
      pump_ok <= 1'b0;
      pump_enable <= 1'b0;
    end
    else
    begin
      // bias starts internal; external level adopted once present
      ext_seen <= s_ext & supply_ok;
      // startup also needs the active shutdown level, else supply_ok chatters
      if (!supply_ok)
        supply_ok <= s_su & sd_ok;
      else if (!sd_ok)
        supply_ok <= 1'b0;
      pump_enable <= supply_ok;
      pump_ok <= supply_ok & (pump_ok | s_cpsu);
    end
  end

  // ---------------------------------------------------------------
  // soft-start and channel run state
  // ---------------------------------------------------------------
  reg [31:0] ss_cnt [0:2];
  reg [2:0] run_q;
  integer i;
  integer j;

  function [15:0] ramp_of;
    input [31:0] cnt;
    reg [47:0] prod;
    reg [47:0] quo;
    begin
      prod = {16'h0000, cnt} * 48'h0000_0000_FFFF;
      quo = prod / SS_CYCLES;
      ramp_of = (SS_CYCLES == 0) ? 16'hFFFF : quo[15:0];
    end
  endfunction

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_q <= 3'b000;
      soft_start_active <= 3'b000;
      channel_run <= 3'b000;
      for (i = 0; i < 3; i = i + 1)
        ss_cnt[i] <= 32'h0000_0000;
    end
    else
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        if (!(s_en[i] & all_ok))
        begin
          run_q[i] <= 1'b0;
          ss_cnt[i] <= 32'h0000_0000;
          soft_start_active[i] <= 1'b0;
        end
        else if (!run_q[i])
        begin
          // fresh enable or fault recovery only; feedback drops don't land here
          run_q[i] <= 1'b1;
          soft_start_active[i] <= 1'b1;
        end
        else if (ss_cnt[i] < SS_CYCLES)
          ss_cnt[i] <= ss_cnt[i] + 32'h0000_0001;
        else
          soft_start_active[i] <= 1'b0;
      end
      channel_run <= run_q;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ref_ramp_1 <= 16'h0000;
      ref_ramp_2 <= 16'h0000;
      ref_ramp_3 <= 16'h0000;
    end
    else
    begin
      ref_ramp_1 <= ramp_of(ss_cnt[0]);
      ref_ramp_2 <= ramp_of(ss_cnt[1]);
      ref_ramp_3 <= ramp_of(ss_cnt[2]);
    end
  end

  // ---------------------------------------------------------------
  // shared switching clock, 3 phases, peak current control
  // ---------------------------------------------------------------
  reg [15:0] sw_cnt;
  wire [2:0] cyc_start;
  assign cyc_start[0] = (sw_cnt == 16'h0000);
  assign cyc_start[1] = (sw_cnt == `TBS_PHASE_STEP);
  assign cyc_start[2] = (sw_cnt == `TBS_PHASE_STEP2);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sw_cnt <= 16'h0000;
      switch_on <= 3'b000;
    end
    else
    begin
      if (sw_cnt == `TBS_SW_PERIOD - 16'h0001)
        sw_cnt <= 16'h0000;
      else
        sw_cnt <= sw_cnt + 16'h0001;
      for (j = 0; j < 3; j = j + 1)
      begin
        if (!run_q[j])
          switch_on[j] <= 1'b0;
        else if (cyc_start[j])
          switch_on[j] <= ~s_skip[j];
        else if (s_dem[j] | s_lim[j])
          switch_on[j] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // power-on-reset timer and power_good_n
  // ---------------------------------------------------------------
  reg [31:0] por_cnt;
  reg [2:0] en_q;
  wire [2:0] en_act = s_en & run_q;
  wire all_up = ((s_fb85 & en_act) == en_act) && (en_act != 3'b000);
  wire any_low = |(s_fb80 & en_act);
  wire new_en = |(s_en & ~en_q);
  wire por_hold = !all_up || any_low || !warn_b || !all_ok || new_en;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      por_cnt <= 32'h0000_0000;
      por_expired <= 1'b0;
      en_q <= 3'b000;
      power_good_n_out <= 1'b0;
      power_good_n_oe_n <= 1'b0;
    end
    else
    begin
      en_q <= s_en;
      if (por_hold)
      begin
        por_cnt <= 32'h0000_0000;
        por_expired <= 1'b0;
      end
      else if (por_cnt < por_count)
        por_cnt <= por_cnt + 32'h0000_0001;
      else
        por_expired <= 1'b1;
      // open drain: oe low pulls low, high releases to pull-up
      power_good_n_out <= 1'b0;
      power_good_n_oe_n <= por_expired & ~por_hold;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  reg aw_got;
  reg w_got;
  reg [11:0] aw_q;
  reg [31:0] w_q;
  reg [3:0] ws_q;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0] be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (be[k])
          merge[k*8 +: 8] = dat[k*8 +: 8];
    end
  endfunction

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= 12'h000;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TBS_RESP_OKAY;
      ctrl <= `TBS_CTRL_RESET;
      por_count <= POR_CYCLES;
    end
    else
    begin
      s_axi_awready <= ~aw_got & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_got & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_got <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_got <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (aw_got & w_got & ~s_axi_bvalid)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `TBS_RESP_OKAY;
        case ({aw_q[11:2], 2'b00})
          `TBS_REG_CTRL: ctrl <= merge(ctrl, w_q, ws_q) & 32'h0000_0001;
          `TBS_REG_POR: por_count <= merge(por_count, w_q, ws_q);
          `TBS_REG_STATUS: s_axi_bresp <= `TBS_RESP_OKAY;
          default: s_axi_bresp <= `TBS_RESP_DECERR;
        endcase
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TBS_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `TBS_RESP_OKAY;
        case ({s_axi_araddr[11:2], 2'b00})
          `TBS_REG_CTRL: s_axi_rdata <= ctrl;
          `TBS_REG_STATUS: s_axi_rdata <= {15'h0000, por_expired, ext_seen, pump_ok,
            supply_ok, s_tsd, 2'b00, run_q, soft_start_active, en_act, ~power_good_n_oe_n};
          `TBS_REG_POR: s_axi_rdata <= por_count;
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TBS_RESP_DECERR;
          end
        endcase
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== tb/tbs_seq_monitor.sv
`timescale 1ns/10ps
module tbs_seq_monitor (
  input wire aclk,
  input wire aresetn,
  input wire [2:0] channel_enable_x,
  input wire [2:0] fb_below_80,
  input wire [2:0] current_at_limit,
  input wire thermal_shutdown,
  input wire above_warning_level,
  input wire [2:0] switch_on,
  input wire [2:0] soft_start_active,
  input wire [2:0] channel_run,
  input wire power_good_n_oe_n
);
  // --------
  // checks
  // --------
  // six cycles cover the two-stage input sync and the state register
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_rst; $rose(aresetn) |-> !power_good_n_oe_n [*8]; endproperty
  a_rst: assert property (p_rst) else $error("flag released at reset exit");
  property p_en; !channel_enable_x[1] [*6] |-> !channel_run[1]; endproperty
  a_en: assert property (p_en) else $error("disabled channel runs");
  property p_ss; $rose(channel_run[0]) |-> soft_start_active[0]; endproperty
  a_ss: assert property (p_ss) else $error("start without ramp");
  // the switch still turns on at each cycle start; the limit must end that pulse
  property p_lim; current_at_limit[0] [*4] ##0 switch_on[0] |=> !switch_on[0]; endproperty
  a_lim: assert property (p_lim) else $error("switch on past limit");
  property p_hot; thermal_shutdown [*6] |-> channel_run == 3'b000 && switch_on == 3'b000;
  endproperty
  a_hot: assert property (p_hot) else $error("channel runs while hot");
  property p_low; ((fb_below_80 & channel_enable_x) != 3'b000) [*6] |-> !power_good_n_oe_n;
  endproperty
  a_low: assert property (p_low) else $error("flag high with low feedback");
  property p_last; (channel_enable_x == 3'b000) [*6] |-> !power_good_n_oe_n; endproperty
  a_last: assert property (p_last) else $error("flag high with all off");
  property p_warn; !above_warning_level [*6] |-> !power_good_n_oe_n; endproperty
  a_warn: assert property (p_warn) else $error("flag high below warning");
  cover property ($rose(power_good_n_oe_n));
  cover property ($rose(soft_start_active[1]));
  cover property (thermal_shutdown && channel_run == 3'b000);
endmodule

bind tbs_seq tbs_seq_monitor mon_u (.aclk, .aresetn, .channel_enable_x, .fb_below_80,
  .current_at_limit, .thermal_shutdown, .above_warning_level, .switch_on,
  .soft_start_active, .channel_run, .power_good_n_oe_n);

// ===== tb/tbs_ctl_model.sv
`timescale 1ns/10ps
module tbs_ctl_model (
  input wire aclk,
  input wire [2:0] want_on,
  input wire soft_restart,
  input wire power_good_n,
  output logic [2:0] channel_enable_x = 3'b000
);
  // --------
  // controller
  // --------
  logic done = 1'b0;
  logic [3:0] off_cnt = 4'h0;
  always @(posedge aclk)
  begin
    // one toggle per request, else it would cycle forever while the flag is low
    if (soft_restart && !power_good_n && !done)
    begin
      off_cnt <= 4'hf;
      done <= 1'b1;
    end
    else if (off_cnt != 4'h0)
      off_cnt <= off_cnt - 4'h1;
    if (!soft_restart)
      done <= 1'b0;
    channel_enable_x <= (off_cnt != 4'h0) ? 3'b000 : want_on;
  end
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
`include "tbs_seq_map.vh"
module tb;
  localparam int SS = 20;
  localparam int POR_W = 40; // longer than the ramp
  logic aclk = 1'b0, aresetn = 1'b0, soft_restart = 1'b0, thermal_shutdown = 1'b0;
  logic above_startup_level = 1'b0, above_combined_startup_level = 1'b0;
  logic above_internal_shutdown_level = 1'b0, above_external_shutdown_level = 1'b0;
  logic above_warning_level = 1'b0, external_logic_supply = 1'b0;
  logic [2:0] want_on = 3'b000, fb_above_85 = 3'b000, fb_below_80 = 3'b111;
  logic [2:0] current_at_limit = 3'b000, current_at_demand = 3'b000, duty_below_min = 3'b000;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire [2:0] channel_enable_x, switch_on, soft_start_active, channel_run;
  wire [15:0] ref_ramp_1, ref_ramp_2, ref_ramp_3;
  wire pump_enable, power_good_n_out, power_good_n_oe_n;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  // open drain with pull-up
  wire power_good_n = power_good_n_oe_n ? 1'b1 : power_good_n_out;
  int error_cnt = 0;
  int comparisons = 0;
  int n;
  always #2 aclk = ~aclk;
  tbs_ctl_model ctl_u (.aclk, .want_on, .soft_restart, .power_good_n, .channel_enable_x);
  tbs_seq #(.SS_CYCLES(SS), .POR_CYCLES(50)) dut_u (
    .aclk, .aresetn, .channel_enable_x, .fb_above_85, .fb_below_80, .current_at_demand,
    .current_at_limit, .duty_below_min, .thermal_shutdown,
    .external_logic_supply, .above_startup_level, .above_combined_startup_level,
    .above_internal_shutdown_level, .above_external_shutdown_level, .above_warning_level,
    .pump_enable, .switch_on, .soft_start_active, .channel_run, .ref_ramp_1,
    .ref_ramp_2, .ref_ramp_3, .power_good_n_out, .power_good_n_oe_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  // --------
  // helpers
  // --------
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    comparisons++;
    if (got !== exp) $display("mismatch %s expected %h seen %h", what, exp, got);
    if (got !== exp) error_cnt++;
  endtask
  task automatic give_up(input string what);
    error_cnt++;
    $display("mismatch %s expected done seen timeout", what);
    end_of_test();
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge aclk);
  endtask
  function automatic logic sig(input int s);
    return s == 0 ? power_good_n : s == 3 ? pump_enable : s == 4 ? switch_on[0] :
      s == 5 ? switch_on[1] : soft_start_active[s-1];
  endfunction
  task automatic wait_for(input int s, input logic v, input int lim);
    n = 0;
    while (sig(s) !== v && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
    comparisons++;
    if (sig(s) !== v) give_up("wait");
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do
    begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && k < 64);
    s_axi_bready <= 1'b0;
    if (!s_axi_bvalid) give_up("bvalid");
    chk("bresp", `TBS_RESP_OKAY, s_axi_bresp);
    // one idle edge so a following call never re-drives a strobe in the same step
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [33:0] d);
    int k = 0;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do
    begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && k < 64);
    s_axi_rready <= 1'b0;
    d = {s_axi_rresp, s_axi_rdata};
    if (!s_axi_rvalid) give_up("rvalid");
    @(posedge aclk);
  endtask
  // --------
  // scenarios
  // --------
  task automatic s_regs();
    logic [33:0] d;
    axi_wr(`TBS_REG_POR, POR_W);
    axi_rd(`TBS_REG_POR, d);
    chk("por_count", {`TBS_RESP_OKAY, 32'(POR_W)}, d);
    axi_rd(12'h00C, d);
    chk("hole", {`TBS_RESP_DECERR, 32'h0000_0000}, d);
  endtask
  task automatic s_power_up();
    want_on <= 3'b001;
    current_at_demand <= 3'b111;
    {above_internal_shutdown_level, above_external_shutdown_level} <= 2'b11;
    above_warning_level <= 1'b1;
    tick(10);
    chk("pump_early", 0, pump_enable);
    above_startup_level <= 1'b1;
    wait_for(3, 1, 10);
    tick(10);
    chk("ss_early", 0, soft_start_active);
    above_combined_startup_level <= 1'b1;
    wait_for(1, 1, 10);
    wait_for(1, 0, SS + 10);
    chk("ramp_end", 16'hffff, ref_ramp_1);
    fb_below_80 <= 3'b110; // disabled channels stay low
    fb_above_85 <= 3'b001;
    wait_for(0, 1, POR_W + 12);
    chk("por_len", 1, n >= POR_W);
  endtask
  task automatic s_add();
    want_on <= 3'b011;
    wait_for(0, 0, 10);
    wait_for(2, 1, 10);
    chk("ramp2_start", 0, ref_ramp_2);
    fb_below_80 <= 3'b100;
    fb_above_85 <= 3'b011;
    wait_for(0, 1, POR_W + SS + 12);
    chk("por_len2", 1, n >= POR_W);
    chk("ramp2_end", 16'hffff, ref_ramp_2);
    chk("ramp3_idle", 0, ref_ramp_3);
  endtask
  task automatic s_switch();
    wait_for(4, 1, 460);
    wait_for(5, 1, 460);
    chk("phase", `TBS_PHASE_STEP, n);
    current_at_demand <= 3'b000;
    tick(4);
    wait_for(4, 1, 460);
    tick(10);
    chk("sw_hold", 1, switch_on[0]);
    current_at_limit[0] <= 1'b1;
    tick(4);
    chk("sw_cut", 0, switch_on[0]);
    {current_at_demand, current_at_limit} <= {3'b111, 3'b000};
    duty_below_min[0] <= 1'b1;
    tick(4);
    n = 0;
    repeat (460)
    begin
      @(posedge aclk);
      if (switch_on[0]) n++;
    end
    chk("skip", 0, n);
    duty_below_min[0] <= 1'b0;
  endtask
  task automatic s_drop();
    fb_below_80[0] <= 1'b1;
    fb_above_85[0] <= 1'b0;
    current_at_limit[0] <= 1'b1;
    wait_for(0, 0, 10);
    tick(7);
    n = switch_on[0];
    tick(1);
    chk("sw_limit", 0, n & switch_on[0]);
    chk("ss_drop", 0, soft_start_active);
    soft_restart <= 1'b1;
    wait_for(1, 1, 30);
    soft_restart <= 1'b0;
    current_at_limit[0] <= 1'b0;
    fb_below_80[0] <= 1'b0;
    fb_above_85[0] <= 1'b1;
    wait_for(0, 1, POR_W + SS + 30);
    chk("por_len3", 1, n >= POR_W);
  endtask
  task automatic s_warn();
    above_warning_level <= 1'b0;
    wait_for(0, 0, 10);
    chk("run_warn", 3'b011, channel_run);
    above_warning_level <= 1'b1;
    wait_for(0, 1, POR_W + 12);
    want_on <= 3'b000;
    wait_for(0, 0, 10);
    tick(6);
    chk("run_off", 0, channel_run);
  endtask
  task automatic s_therm();
    want_on <= 3'b011;
    thermal_shutdown <= 1'b1;
    tick(8);
    chk("run_hot", 0, channel_run);
    thermal_shutdown <= 1'b0;
    wait_for(2, 1, 10);
    above_internal_shutdown_level <= 1'b0;
    tick(8);
    chk("run_uv", 0, channel_run);
  endtask
  task automatic s_ext();
    logic [33:0] d;
    above_internal_shutdown_level <= 1'b1;
    external_logic_supply <= 1'b1;
    wait_for(2, 1, 20);
    tick(4);
    above_internal_shutdown_level <= 1'b0;
    tick(8);
    chk("run_ext", 3'b011, channel_run);
    axi_wr(`TBS_REG_CTRL, 32'h0000_0001);
    tick(6);
    chk("run_hold", 0, channel_run);
    axi_rd(`TBS_REG_STATUS, d);
    chk("status", {`TBS_RESP_OKAY, 32'h0000_E001}, d);
    axi_wr(`TBS_REG_CTRL, 32'h0000_0000);
    above_external_shutdown_level <= 1'b0;
    tick(8);
    chk("run_uv_ext", 0, channel_run);
  endtask
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    s_regs();
    s_power_up();
    s_add();
    s_switch();
    s_drop();
    s_warn();
    s_therm();
    s_ext();
    end_of_test();
  end
endmodule
